/* src/irq_front.sv */
// interrupt front end: vector placement, dedicated pins and pin-change groups
`timescale 1ns/1ps
`default_nettype none
`include "irq_front_defs.svh"
module irq_front
  import irq_front_pkg::*;
#(
  parameter bit          HAS_BOOT_SECTION = 1'b1,
  parameter logic [12:0] BOOT_START_SZ0   = 13'h1000,
  parameter logic [12:0] BOOT_START_SZ1   = 13'h1800,
  parameter logic [12:0] BOOT_START_SZ2   = 13'h1C00,
  parameter logic [12:0] BOOT_START_SZ3   = 13'h1E00
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        io_clock_enable,
  input  wire logic        global_irq_enable,
  input  wire logic        instr_retire,
  input  wire logic        executing_boot,
  input  wire logic [1:0]  boot_size_fuses,
  input  wire logic        app_boot_lock_bit,
  input  wire logic        boot_side_lock_bit,
  input  wire logic [1:0]  ext_irq_pins,
  input  wire logic [23:0] pin_change_pins,
  input  wire logic [4:0]  irq_ack,
  output logic [4:0]       irq_request,
  output logic [12:0]      vector_base,
  output logic             wake_request
);
  // a zero boot start could not be told apart from the flash vector base
  if ((BOOT_START_SZ0 == 13'h0000) || (BOOT_START_SZ1 == 13'h0000) ||
      (BOOT_START_SZ2 == 13'h0000) || (BOOT_START_SZ3 == 13'h0000)) begin : g_bad_boot_start
    $error("boot start must not be zero");
  end

  // ------------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------------
  logic        setup_phase;
  logic        wr_strobe;
  logic        addr_hit;
  logic        wr_mcu, wr_sense, wr_emask, wr_eflag, wr_pcctl, wr_pcflag;
  logic        wr_m0, wr_m1, wr_m2;
  logic [7:0]  wbyte;

  function automatic logic is_wr(input logic [11:0] a, input logic [11:0] ofs);
    is_wr = (a == ofs);
  endfunction : is_wr

  assign setup_phase = psel && !penable;
  assign wr_strobe   = psel && penable && pwrite;
  assign wbyte       = pwdata[7:0];
  assign wr_mcu      = wr_strobe && is_wr(paddr, `OFS_MCU_CONTROL);
  assign wr_sense    = wr_strobe && is_wr(paddr, `OFS_SENSE_CONTROL);
  assign wr_emask    = wr_strobe && is_wr(paddr, `OFS_EXT_MASK);
  assign wr_eflag    = wr_strobe && is_wr(paddr, `OFS_EXT_FLAGS);
  assign wr_pcctl    = wr_strobe && is_wr(paddr, `OFS_PC_CONTROL);
  assign wr_pcflag   = wr_strobe && is_wr(paddr, `OFS_PC_FLAGS);
  assign wr_m0       = wr_strobe && is_wr(paddr, `OFS_PC_MASK_ZERO);
  assign wr_m1       = wr_strobe && is_wr(paddr, `OFS_PC_MASK_ONE);
  assign wr_m2       = wr_strobe && is_wr(paddr, `OFS_PC_MASK_TWO);
  assign addr_hit    = (paddr[1:0] == 2'h0) && (paddr <= `OFS_REQ_STATUS);

  // ------------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------------
  logic [3:0] sense_reg;
  logic [1:0] emask_reg;
  logic [2:0] pcctl_reg;
  logic [7:0] mask0_reg, mask1_reg, mask2_reg;

  // mask one has only seven live pins; bit 7 stays zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_reg <= 4'h0;
      emask_reg <= 2'h0;
      pcctl_reg <= 3'h0;
      mask0_reg <= `RESET_BYTE;
      mask1_reg <= `RESET_BYTE;
      mask2_reg <= `RESET_BYTE;
    end else begin
      if (wr_sense) sense_reg <= wbyte[3:0];
      if (wr_emask) emask_reg <= wbyte[1:0];
      if (wr_pcctl) pcctl_reg <= wbyte[2:0];
      if (wr_m0) mask0_reg <= wbyte;
      if (wr_m1) mask1_reg <= {1'b0, wbyte[6:0]};
      if (wr_m2) mask2_reg <= wbyte;
    end
  end

  // ------------------------------------------------------------------------
  // vector relocation sequence
  // ------------------------------------------------------------------------
  seq_state_t state_reg, state_next;
  logic       vsel_reg, vsel_next;
  logic [2:0] win_reg, win_next;
  logic [1:0] hold_reg, hold_next;
  logic       ce_write, sel_write;

  // software is expected to set enable, then write select with enable at zero
  assign ce_write  = wr_mcu && wbyte[`BIT_VECTOR_CHANGE_ENABLE] && HAS_BOOT_SECTION;
  assign sel_write = wr_mcu && !wbyte[`BIT_VECTOR_CHANGE_ENABLE] && HAS_BOOT_SECTION;

  always_comb begin
    state_next = state_reg;
    vsel_next  = vsel_reg;
    win_next   = win_reg;
    hold_next  = hold_reg;
    case (state_reg)
      SEQ_IDLE: begin
        if (ce_write) begin
          state_next = SEQ_OPEN;
          win_next   = `CHANGE_WINDOW_CYCLES;
        end
      end
      SEQ_OPEN: begin
        if (sel_write) begin
          vsel_next  = wbyte[`BIT_VECTOR_TABLE_SELECT];
          state_next = SEQ_HOLD;
          hold_next  = `HOLD_RETIRE_COUNT;
        end else if (win_reg == 3'h1) begin
          state_next = SEQ_IDLE;
        end else begin
          win_next = win_reg - 3'h1;
        end
      end
      SEQ_HOLD: begin
        // the select write retires, then one more instruction
        if (instr_retire) begin
          if (hold_reg == 2'h1) state_next = SEQ_IDLE;
          else hold_next = hold_reg - 2'h1;
        end
      end
      default: state_next = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SEQ_IDLE;
      vsel_reg  <= 1'b0;
      win_reg   <= 3'h0;
      hold_reg  <= 2'h0;
    end else begin
      state_reg <= state_next;
      vsel_reg  <= vsel_next;
      win_reg   <= win_next;
      hold_reg  <= hold_next;
    end
  end

  logic        auto_mask;
  logic        ce_bit;
  logic [12:0] boot_start;

  // masking is local; the global enable input is only read, never changed
  assign auto_mask = (state_reg != SEQ_IDLE);
  assign ce_bit    = (state_reg == SEQ_OPEN);
  assign boot_start = (boot_size_fuses == 2'h0) ? BOOT_START_SZ0 :
                      (boot_size_fuses == 2'h1) ? BOOT_START_SZ1 :
                      (boot_size_fuses == 2'h2) ? BOOT_START_SZ2 : BOOT_START_SZ3;
  assign vector_base = vsel_reg ? boot_start : 13'h0000;

  // ------------------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------------------
  logic [25:0] pins_stable;
  logic [25:0] pins_changed;

  // pins are read from the pad whatever their direction, so software can
  // raise interrupts by driving them
  pin_sampler #(
    .WIDTH (26)
  ) u_sampler (
    .pclk         (pclk),
    .presetn      (presetn),
    .sample_en    (io_clock_enable),
    .pins_raw     ({ext_irq_pins, pin_change_pins}),
    .pins_stable  (pins_stable),
    .pins_changed (pins_changed)
  );

  // ------------------------------------------------------------------------
  // dedicated pin detection
  // ------------------------------------------------------------------------
  logic [1:0] ext_now, ext_chg, ext_trig, ext_level, ext_low_mode;
  logic [1:0] eflag_reg, eflag_next;

  assign ext_now = pins_stable[25:24];
  assign ext_chg = pins_changed[25:24];

  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_ext
      logic [1:0] mode;
      assign mode = sense_reg[2*k +: 2];
      assign ext_low_mode[k] = (mode == `SENSE_LOW_LEVEL);
      assign ext_trig[k] = ext_chg[k] && (
                           (mode == `SENSE_ANY_CHANGE) ||
                           (mode == `SENSE_FALLING && !ext_now[k]) ||
                           (mode == `SENSE_RISING && ext_now[k]));
      assign ext_level[k] = ext_low_mode[k] && !ext_now[k];
      // set beats clear; level mode keeps the flag at zero
      assign eflag_next[k] = ext_low_mode[k] ? 1'b0 :
                             ext_trig[k] ? 1'b1 :
                             ((wr_eflag && wbyte[k]) || irq_ack[k]) ? 1'b0 : eflag_reg[k];
    end
  endgenerate

  // ------------------------------------------------------------------------
  // pin-change groups
  // ------------------------------------------------------------------------
  logic [2:0] pc_trig;
  logic [2:0] pcflag_reg, pcflag_next;

  assign pc_trig[0] = |(pins_changed[7:0] & mask0_reg);
  assign pc_trig[1] = |(pins_changed[14:8] & mask1_reg[6:0]);
  assign pc_trig[2] = |(pins_changed[23:16] & mask2_reg);
  // set beats clear on the same cycle
  assign pcflag_next = pc_trig |
                       (pcflag_reg & ~((wr_pcflag ? wbyte[2:0] : 3'h0) | irq_ack[4:2]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eflag_reg  <= 2'h0;
      pcflag_reg <= 3'h0;
    end else begin
      eflag_reg  <= eflag_next;
      pcflag_reg <= pcflag_next;
    end
  end

  // ------------------------------------------------------------------------
  // wake path
  // ------------------------------------------------------------------------
  logic [23:0] pc_enabled_pins;
  logic        pc_diff;
  logic        low_wake;

  // combinational from the pads so it works with the I/O clock stopped;
  // a level dropped before start-up wakes but leaves no request
  assign pc_enabled_pins = {mask2_reg & {8{pcctl_reg[2]}}, 1'b0,
                            mask1_reg[6:0] & {7{pcctl_reg[1]}},
                            mask0_reg & {8{pcctl_reg[0]}}};
  assign pc_diff  = |((pin_change_pins ^ pins_stable[23:0]) & pc_enabled_pins);
  assign low_wake = |(~ext_irq_pins & ext_low_mode & emask_reg);
  assign wake_request = pc_diff || low_wake;

  // ------------------------------------------------------------------------
  // request gating
  // ------------------------------------------------------------------------
  logic       lock_block;
  logic [4:0] pending;

  assign lock_block = HAS_BOOT_SECTION &&
                      ((vsel_reg && app_boot_lock_bit && !executing_boot) ||
                       (!vsel_reg && boot_side_lock_bit && executing_boot));
  assign pending = {pcflag_reg, eflag_reg | ext_level};
  assign irq_request = pending & {pcctl_reg, emask_reg} &
                       {5{global_irq_enable && !auto_mask && !lock_block}};

  // ------------------------------------------------------------------------
  // read data and response
  // ------------------------------------------------------------------------
  logic [7:0]  rbyte;
  logic [31:0] prdata_reg;
  logic        err_reg;

  assign rbyte =
    (paddr == `OFS_MCU_CONTROL)   ? {6'h00, vsel_reg, ce_bit} :
    (paddr == `OFS_SENSE_CONTROL) ? {4'h0, sense_reg} :
    (paddr == `OFS_EXT_MASK)      ? {6'h00, emask_reg} :
    (paddr == `OFS_EXT_FLAGS)     ? {6'h00, eflag_reg} :
    (paddr == `OFS_PC_CONTROL)    ? {5'h00, pcctl_reg} :
    (paddr == `OFS_PC_FLAGS)      ? {5'h00, pcflag_reg} :
    (paddr == `OFS_PC_MASK_ZERO)  ? mask0_reg :
    (paddr == `OFS_PC_MASK_ONE)   ? mask1_reg :
    (paddr == `OFS_PC_MASK_TWO)   ? mask2_reg :
    (paddr == `OFS_REQ_STATUS)    ? {3'h0, irq_request} : 8'h00;

  // captured in the setup cycle so the access phase needs no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      err_reg    <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg <= {24'h000000, rbyte};
      err_reg    <= !addr_hit;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_reg;
endmodule : irq_front
`default_nettype wire

/* src/irq_front_defs.svh */
// register map, field positions, reset values and timing counts of the interrupt front end
`ifndef IRQ_FRONT_DEFS_SVH
`define IRQ_FRONT_DEFS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_MCU_CONTROL   12'h000
`define OFS_SENSE_CONTROL 12'h004
`define OFS_EXT_MASK      12'h008
`define OFS_EXT_FLAGS     12'h00C
`define OFS_PC_CONTROL    12'h010
`define OFS_PC_FLAGS      12'h014
`define OFS_PC_MASK_ZERO  12'h018
`define OFS_PC_MASK_ONE   12'h01C
`define OFS_PC_MASK_TWO   12'h020
`define OFS_REQ_STATUS    12'h024

// ----------------------------------------------------------------------------
// fields and codes
// ----------------------------------------------------------------------------
`define BIT_VECTOR_CHANGE_ENABLE 0
`define BIT_VECTOR_TABLE_SELECT  1
`define SENSE_LOW_LEVEL 2'h0
`define SENSE_ANY_CHANGE 2'h1
`define SENSE_FALLING    2'h2
`define SENSE_RISING     2'h3
`define RESET_BYTE       8'h00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CHANGE_WINDOW_CYCLES 3'h4
`define HOLD_RETIRE_COUNT    2'h2

`endif

/* src/irq_front_pkg.sv */
// types shared by the interrupt front end
package irq_front_pkg;
  // progress of the vector relocation sequence
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_OPEN, SEQ_HOLD} seq_state_t;
endpackage : irq_front_pkg

/* src/pin_sampler.sv */
// three-stage pin sampler with agreement filter and change detect
`timescale 1ns/1ps
`default_nettype none
module pin_sampler #(
  parameter int WIDTH = 26
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             sample_en,
  input  wire logic [WIDTH-1:0] pins_raw,
  output logic      [WIDTH-1:0] pins_stable,
  output logic      [WIDTH-1:0] pins_changed
);
  // refused at elaboration
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sampler width must be positive");
  end

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] changed_reg;

  // ------------------------------------------------------------------------
  // per-bit chain
  // ------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      // stage1 feeds stage2 only; a value counts once stage2 and stage3 agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage1_reg[g]  <= 1'b1;
          stage2_reg[g]  <= 1'b1;
          stage3_reg[g]  <= 1'b1;
          stable_reg[g]  <= 1'b1;
          changed_reg[g] <= 1'b0;
        end else if (sample_en) begin
          stage1_reg[g]  <= pins_raw[g];
          stage2_reg[g]  <= stage1_reg[g];
          stage3_reg[g]  <= stage2_reg[g];
          if (stage2_reg[g] == stage3_reg[g]) begin
            stable_reg[g]  <= stage3_reg[g];
            changed_reg[g] <= stage3_reg[g] ^ stable_reg[g];
          end else begin
            changed_reg[g] <= 1'b0;
          end
        end else begin
          changed_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign pins_stable  = stable_reg;
  assign pins_changed = changed_reg;
endmodule : pin_sampler
`default_nettype wire

/* testbench/irq_front_chk.sv */
// port-level assertion checker for the interrupt front end
`timescale 1ns/1ps
`default_nettype none
module irq_front_chk
  import irq_front_pkg::*;
#(
  parameter logic [12:0] BOOT_START_SZ0 = 13'h1000,
  parameter logic [12:0] BOOT_START_SZ1 = 13'h1800,
  parameter logic [12:0] BOOT_START_SZ2 = 13'h1C00,
  parameter logic [12:0] BOOT_START_SZ3 = 13'h1E00
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        instr_retire,
  input wire logic        executing_boot,
  input wire logic [1:0]  boot_size_fuses,
  input wire logic        app_boot_lock_bit,
  input wire logic        boot_side_lock_bit,
  input wire logic        global_irq_enable,
  input wire logic [4:0]  irq_request,
  input wire logic [12:0] vector_base
);
  // ---------------------------------------------------------------
  // helper decode
  // ---------------------------------------------------------------
  // writes to mcu_control, split into enable and select writes
  wire        mcu_wr     = psel & penable & pwrite & (paddr == 12'h000);
  wire        en_wr      = mcu_wr & pwdata[0];
  wire        sel_wr     = mcu_wr & ~pwdata[0];
  wire [12:0] boot_start = (boot_size_fuses == 2'h0) ? BOOT_START_SZ0 :
                           (boot_size_fuses == 2'h1) ? BOOT_START_SZ1 :
                           (boot_size_fuses == 2'h2) ? BOOT_START_SZ2 : BOOT_START_SZ3;
  logic [2:0] age_reg;
  wire  [2:0] age_next   = en_wr ? 3'h1 : (age_reg == 3'h7) ? 3'h7 : age_reg + 3'h1;
  // cycles since last enable write; saturates so stale windows never match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) age_reg <= 3'h7;
    else age_reg <= age_next;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_base_value;
    vector_base != 13'h0000 |-> vector_base == boot_start;
  endproperty
  a_base_value: assert property (p_base_value) else $error("vector base not fuse start");
  property p_fuse_follow;
    $changed(boot_size_fuses) && $past(vector_base) != 13'h0000 |-> $changed(vector_base);
  endproperty
  a_fuse_follow: assert property (p_fuse_follow) else $error("base ignores fuses");
  property p_sel_window;
    $changed(vector_base) && $stable(boot_size_fuses) |-> $past(sel_wr) && $past(age_reg) <= 3'h5;
  endproperty
  a_sel_window: assert property (p_sel_window) else $error("select moved outside window");
  property p_auto_mask;
    en_wr |=> (irq_request == 5'h00) [*3];
  endproperty
  a_auto_mask: assert property (p_auto_mask) else $error("request during change window");
  property p_hold_mask;
    sel_wr && age_reg <= 3'h3 ##1 (!instr_retire) [*3] |-> irq_request == 5'h00;
  endproperty
  a_hold_mask: assert property (p_hold_mask) else $error("mask dropped before retire");
  property p_global;
    irq_request != 5'h00 |-> global_irq_enable;
  endproperty
  a_global: assert property (p_global) else $error("request without global enable");
  property p_lock_app;
    vector_base != 13'h0000 && app_boot_lock_bit && !executing_boot |-> irq_request == 5'h00;
  endproperty
  a_lock_app: assert property (p_lock_app) else $error("request in locked app code");
  property p_lock_boot;
    vector_base == 13'h0000 && boot_side_lock_bit && executing_boot |-> irq_request == 5'h00;
  endproperty
  a_lock_boot: assert property (p_lock_boot) else $error("request in locked boot code");
endmodule : irq_front_chk
bind irq_front irq_front_chk #(.BOOT_START_SZ0(BOOT_START_SZ0), .BOOT_START_SZ1(BOOT_START_SZ1),
  .BOOT_START_SZ2(BOOT_START_SZ2), .BOOT_START_SZ3(BOOT_START_SZ3)) u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .instr_retire, .executing_boot, .boot_size_fuses,
  .app_boot_lock_bit, .boot_side_lock_bit, .global_irq_enable, .irq_request, .vector_base);
`default_nettype wire

/* testbench/pin_source.sv */
// model of the external circuitry that drives the interrupt pads
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input  wire logic        pclk,
  output logic      [1:0]  ext_irq_pins,
  output logic      [23:0] pin_change_pins
);
  // pads idle high, matching the sampler reset value
  initial begin
    ext_irq_pins    = 2'h3;
    pin_change_pins = 24'hFFFFFF;
  end
  // push-pull drive, so a pad never floats; like firmware toggling an output pin
  task automatic drive(input logic [1:0] e, input logic [23:0] p);
    @(posedge pclk);
    ext_irq_pins    <= e;
    pin_change_pins <= p;
    repeat (8) @(posedge pclk);
  endtask : drive
endmodule : pin_source
`default_nettype wire

/* testbench/vector_select_ext_irq_detect_test.sv */
// self-checking bench for the interrupt front end
`timescale 1ns/1ps
`default_nettype none
`include "irq_front_defs.svh"
module vector_select_ext_irq_detect_test
  import irq_front_pkg::*;
;
  localparam logic [12:0] SZ1 = 13'h1800;
  localparam logic [12:0] SZ3 = 13'h1E00;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic        io_clock_enable, global_irq_enable, instr_retire, executing_boot;
  logic        app_boot_lock_bit, boot_side_lock_bit, wake_request;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [1:0]  boot_size_fuses, ext_irq_pins;
  logic [23:0] pin_change_pins, pins;
  logic [4:0]  irq_ack, irq_request;
  logic [12:0] vector_base;
  int          num_errors, check_count;
  irq_front #(.BOOT_START_SZ1(SZ1), .BOOT_START_SZ3(SZ3)) dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .io_clock_enable,
    .global_irq_enable, .instr_retire, .executing_boot, .boot_size_fuses, .app_boot_lock_bit,
    .boot_side_lock_bit, .ext_irq_pins, .pin_change_pins, .irq_ack, .irq_request,
    .vector_base, .wake_request);
  pin_source src (.pclk, .ext_irq_pins, .pin_change_pins);
  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; answer taken at the edge where pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rd
  task automatic retire2;
    repeat (2) begin
      @(posedge pclk);
      instr_retire <= 1'b1;
      @(posedge pclk);
      instr_retire <= 1'b0;
    end
  endtask : retire2
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 10; i++) rd(12'(4 * i), 32'h0);
    chk(vector_base, 32'h0);
    rd(12'h030, 32'h0);
    chk(rerr, 32'h1);
  endtask : t_regs
  task automatic t_level;
    wr(`OFS_SENSE_CONTROL, 32'h0);
    wr(`OFS_EXT_MASK, 32'h1);
    src.drive(2'b10, pins);
    @(negedge pclk);
    chk(irq_request, 32'h1);
    chk(wake_request, 32'h1);
    rd(`OFS_EXT_FLAGS, 32'h0);
    global_irq_enable <= 1'b0;
    @(negedge pclk);
    chk(irq_request, 32'h0);
    @(posedge pclk);
    global_irq_enable <= 1'b1;
  endtask : t_level
  // level request on pin zero stays masked through the relocation sequence
  task automatic t_vector;
    boot_size_fuses <= 2'h1;
    wr(`OFS_MCU_CONTROL, 32'h1);
    @(negedge pclk);
    chk(irq_request, 32'h0);
    wr(`OFS_MCU_CONTROL, 32'h2);
    @(negedge pclk);
    chk(vector_base, SZ1);
    chk(irq_request, 32'h0);
    // no retire yet: the mask must hold however long that takes
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk(irq_request, 32'h0);
    retire2();
    @(negedge pclk);
    chk(irq_request, 32'h1);
    rd(`OFS_MCU_CONTROL, 32'h2);
    boot_size_fuses   <= 2'h3;
    app_boot_lock_bit <= 1'b1;
    @(negedge pclk);
    chk(vector_base, SZ3);
    chk(irq_request, 32'h0);
    @(posedge pclk);
    executing_boot <= 1'b1;
    @(negedge pclk);
    chk(irq_request, 32'h1);
    @(posedge pclk);
    executing_boot    <= 1'b0;
    app_boot_lock_bit <= 1'b0;
    wr(`OFS_MCU_CONTROL, 32'h0);
    wr(`OFS_MCU_CONTROL, 32'h1);
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk(irq_request, 32'h1);
    wr(`OFS_MCU_CONTROL, 32'h0);
    @(negedge pclk);
    chk(vector_base, SZ3);
    wr(`OFS_MCU_CONTROL, 32'h1);
    wr(`OFS_MCU_CONTROL, 32'h0);
    retire2();
    @(negedge pclk);
    chk(vector_base, 32'h0);
    @(posedge pclk);
    boot_side_lock_bit <= 1'b1;
    executing_boot     <= 1'b1;
    @(negedge pclk);
    chk(irq_request, 32'h0);
    @(posedge pclk);
    boot_side_lock_bit <= 1'b0;
    executing_boot     <= 1'b0;
  endtask : t_vector
  // both pins share one sense code; every edge code is walked
  task automatic t_edges;
    wr(`OFS_EXT_MASK, 32'h3);
    src.drive(2'b00, pins);
    for (int c = 1; c < 4; c++) begin
      wr(`OFS_SENSE_CONTROL, 32'(c * 5));
      src.drive(2'b11, pins);
      @(negedge pclk);
      chk(irq_request, (c != 2) ? 32'h3 : 32'h0);
      wr(`OFS_EXT_FLAGS, 32'h3);
      rd(`OFS_EXT_FLAGS, 32'h0);
      src.drive(2'b00, pins);
      rd(`OFS_EXT_FLAGS, (c != 3) ? 32'h3 : 32'h0);
      wr(`OFS_EXT_FLAGS, 32'h3);
    end
    src.drive(2'b11, pins);
    irq_ack <= 5'h03;
    @(posedge pclk);
    irq_ack <= 5'h00;
    rd(`OFS_EXT_FLAGS, 32'h0);
  endtask : t_edges
  // masked-out pins first, then one enabled pin per group, then a stopped i/o clock
  task automatic t_pins;
    wr(`OFS_PC_CONTROL, 32'h7);
    wr(`OFS_PC_MASK_ZERO, 32'h1);
    wr(`OFS_PC_MASK_ONE, 32'h40);
    wr(`OFS_PC_MASK_TWO, 32'h80);
    pins = pins ^ 24'h018002;
    src.drive(2'b11, pins);
    rd(`OFS_PC_FLAGS, 32'h0);
    for (int g = 0; g < 3; g++) begin
      pins[(g == 0) ? 0 : (g == 1) ? 14 : 23] ^= 1'b1;
      src.drive(2'b11, pins);
      rd(`OFS_REQ_STATUS, 32'h4 << g);
      wr(`OFS_PC_FLAGS, 32'h7);
      rd(`OFS_PC_FLAGS, 32'h0);
    end
    wr(`OFS_SENSE_CONTROL, 32'hA);
    io_clock_enable <= 1'b0;
    pins[0] ^= 1'b1;
    src.drive(2'b10, pins);
    @(negedge pclk);
    chk(wake_request, 32'h1);
    rd(`OFS_EXT_FLAGS, 32'h0);
    io_clock_enable <= 1'b1;
  endtask : t_pins
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    presetn            <= 1'b0;
    psel               <= 1'b0;
    penable            <= 1'b0;
    pwrite             <= 1'b0;
    paddr              <= 12'h000;
    pwdata             <= 32'h0;
    io_clock_enable    <= 1'b1;
    global_irq_enable  <= 1'b1;
    instr_retire       <= 1'b0;
    executing_boot     <= 1'b0;
    boot_size_fuses    <= 2'h0;
    app_boot_lock_bit  <= 1'b0;
    boot_side_lock_bit <= 1'b0;
    irq_ack            <= 5'h00;
    pins = 24'hFFFFFF;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_level();
    t_vector();
    t_edges();
    t_pins();
    tally_and_finish();
  end
  // generous bound over the roughly 340 cycles the scenarios need
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end
endmodule : vector_select_ext_irq_detect_test
`default_nettype wire
